// file: design/spsl_pkg.sv
// constants for the service port serial link
package spsl_pkg;
    // timing
    localparam int CLOCK_HZ = 100_000_000;
    localparam int BAUD_RATE = 19200;
    localparam int BIT_CYCLES = CLOCK_HZ / BAUD_RATE;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    // framing
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    // in-band flow characters
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    // register map: index on the plain port
    localparam logic [1:0] REG_DATA = 2'h0;
    localparam logic [1:0] REG_CTRL = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    // control fields
    localparam int CTRL_FLOW_SW = 0;
    localparam int CTRL_DTR = 1;
    localparam int CTRL_RTS = 2;
    localparam logic [2:0] CTRL_RESET = 3'h6;
    // status fields
    localparam int ST_TX_BUSY = 0;
    localparam int ST_RX_VALID = 1;
    localparam int ST_RX_OVERRUN = 2;
    localparam int ST_RX_FRAME_ERR = 3;
    localparam int ST_PAUSED = 4;
    localparam int ST_CTS = 5;
    localparam int ST_DSR = 6;
endpackage

// file: design/spsl_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module spsl_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // pin and clean level
    input wire logic pin_i,
    output logic level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } spsl_sync_state_type;

    spsl_sync_state_type state_reg;
    spsl_sync_state_type state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.s1 = pin_i;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        // change only once stages two and three agree
        if (state_reg.s2 == state_reg.s3)
        begin
            state_next.level = state_reg.s3;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= {4{RESET_VALUE}};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign level_o = state_reg.level;
endmodule

// file: design/spsl_top.sv
// service port serial link: transmitter, receiver and flow control
`timescale 1ns/1ps
// What this block does
// R1 - Both directions run at a fixed 19200 baud, and the terminal must match.
// R2 - Every character carries eight data bits and no parity bit.
// R3 - Every character ends with exactly one stop bit.
// R4 - Flow control is either RTS/CTS handshaking or Xon/Xoff, same on both ends.
// R5 - The port is data terminal equipment, sending on TD and sampling RD.
// R6 - TD, DTR and RTS are outputs; RD, CD, DSR, CTS and RI are inputs.
// R7 - Carrier detect and ring indicator are ignored.
// R8 - The far RTS drives our CTS and our RTS drives the far CTS.
// R9 - The far DTR drives our DSR and our DTR drives the far DSR.
// R10 - The far party sends on our RD and receives our TD.
// R11 - A new character waits while CTS is low (hardware) or after Xoff until Xon (software).
module spsl_top (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // register port
    input wire logic [1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // serial pins
    input wire logic RXD_I,
    input wire logic CTS_N_I,
    input wire logic DSR_N_I,
    input wire logic DCD_N_I,
    input wire logic RI_N_I,
    output logic TXD_O,
    output logic RTS_N_O,
    output logic DTR_N_O
);
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } spsl_tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } spsl_rx_state_type;

    localparam int CW = $clog2(spsl_pkg::BIT_CYCLES + 1);
    localparam logic [CW-1:0] BIT_LAST = CW'(spsl_pkg::BIT_CYCLES - 1);
    localparam logic [CW-1:0] HALF_LAST = CW'(spsl_pkg::HALF_CYCLES - 1);
    localparam logic [2:0] LAST_BIT = 3'(spsl_pkg::DATA_BITS - 1);

    typedef struct packed {
        logic [2:0] ctrl;
        // transmitter
        spsl_tx_state_type tx_state;
        logic [CW-1:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_shift;
        logic tx_pending;
        logic [7:0] tx_hold;
        logic txd;
        logic paused;
        // receiver
        spsl_rx_state_type rx_state;
        logic [CW-1:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_shift;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_overrun;
        logic rx_frame_err;
        // port
        logic [7:0] rdata;
        logic rts_n;
        logic dtr_n;
    } spsl_state_type;

    spsl_state_type state_reg;
    spsl_state_type state_next;

    logic rxd;
    logic cts_n;
    logic dsr_n;

    // pins from the far party cross three stages [R10] [R8] [R9]
    spsl_sync #(.RESET_VALUE(1'b1)) u_sync_rxd (
        .clock_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .pin_i(RXD_I),
        .level_o(rxd)
    );
    spsl_sync #(.RESET_VALUE(1'b1)) u_sync_cts (
        .clock_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .pin_i(CTS_N_I),
        .level_o(cts_n)
    );
    spsl_sync #(.RESET_VALUE(1'b1)) u_sync_dsr (
        .clock_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .pin_i(DSR_N_I),
        .level_o(dsr_n)
    );

    // carrier detect and ring indicator are deliberately left unread [R7]
    logic unused_pins;
    assign unused_pins = DCD_N_I ^ RI_N_I;

    logic flow_sw;
    logic rx_done;
    logic [7:0] rx_char;
    logic may_start;

    always_comb
    begin
        state_next = state_reg;
        flow_sw = state_reg.ctrl[spsl_pkg::CTRL_FLOW_SW];
        rx_done = 1'b0;
        rx_char = state_reg.rx_shift;

        // ============================================================
        // register port
        state_next.rdata = 8'h00;
        if (WR_I)
        begin
            case (ADDR_I)
                spsl_pkg::REG_DATA:
                begin
                    // write while a byte waits is dropped; software polls busy
                    if (!state_reg.tx_pending)
                    begin
                        state_next.tx_hold = WDATA_I;
                        state_next.tx_pending = 1'b1;
                    end
                end
                spsl_pkg::REG_CTRL:
                begin
                    state_next.ctrl = WDATA_I[2:0];
                end
                default:
                begin
                end
            endcase
        end
        if (RD_I)
        begin
            case (ADDR_I)
                spsl_pkg::REG_DATA:
                begin
                    state_next.rdata = state_reg.rx_data;
                    state_next.rx_valid = 1'b0;
                    state_next.rx_overrun = 1'b0;
                    state_next.rx_frame_err = 1'b0;
                end
                spsl_pkg::REG_CTRL:
                begin
                    state_next.rdata = {5'h00, state_reg.ctrl};
                end
                spsl_pkg::REG_STATUS:
                begin
                    state_next.rdata[spsl_pkg::ST_TX_BUSY] =
                        state_reg.tx_pending || (state_reg.tx_state != TX_IDLE);
                    state_next.rdata[spsl_pkg::ST_RX_VALID] = state_reg.rx_valid;
                    state_next.rdata[spsl_pkg::ST_RX_OVERRUN] = state_reg.rx_overrun;
                    state_next.rdata[spsl_pkg::ST_RX_FRAME_ERR] = state_reg.rx_frame_err;
                    state_next.rdata[spsl_pkg::ST_PAUSED] = state_reg.paused;
                    state_next.rdata[spsl_pkg::ST_CTS] = !cts_n;
                    state_next.rdata[spsl_pkg::ST_DSR] = !dsr_n;
                end
                default:
                begin
                end
            endcase
        end

        // ============================================================
        // receiver, 8N1 sampled mid-bit [R5] [R2] [R3] [R1]
        case (state_reg.rx_state)
            RX_IDLE:
            begin
                if (!rxd)
                begin
                    state_next.rx_state = RX_START;
                    state_next.rx_cnt = '0;
                end
            end
            RX_START:
            begin
                state_next.rx_cnt = state_reg.rx_cnt + 1'b1;
                if (state_reg.rx_cnt == HALF_LAST)
                begin
                    state_next.rx_cnt = '0;
                    // glitch shorter than half a bit is not a start
                    state_next.rx_state = rxd ? RX_IDLE : RX_DATA;
                    state_next.rx_bit = '0;
                end
            end
            RX_DATA:
            begin
                state_next.rx_cnt = state_reg.rx_cnt + 1'b1;
                if (state_reg.rx_cnt == BIT_LAST)
                begin
                    state_next.rx_cnt = '0;
                    state_next.rx_shift = {rxd, state_reg.rx_shift[7:1]};
                    state_next.rx_bit = state_reg.rx_bit + 1'b1;
                    if (state_reg.rx_bit == LAST_BIT)
                    begin
                        state_next.rx_state = RX_STOP;
                    end
                end
            end
            RX_STOP:
            begin
                state_next.rx_cnt = state_reg.rx_cnt + 1'b1;
                if (state_reg.rx_cnt == BIT_LAST)
                begin
                    state_next.rx_state = RX_IDLE;
                    rx_done = 1'b1;
                end
            end
            default:
            begin
                state_next.rx_state = RX_IDLE;
            end
        endcase

        // flow characters are consumed in software mode [R11] [R4]
        if (rx_done && flow_sw && (rx_char == spsl_pkg::XOFF_CHAR))
        begin
            state_next.paused = 1'b1;
        end
        else if (rx_done && flow_sw && (rx_char == spsl_pkg::XON_CHAR))
        begin
            state_next.paused = 1'b0;
        end
        else if (rx_done)
        begin
            // new data wins over a same-cycle read clear
            if (state_reg.rx_valid && !(RD_I && ADDR_I == spsl_pkg::REG_DATA))
            begin
                state_next.rx_overrun = 1'b1;
            end
            state_next.rx_data = rx_char;
            state_next.rx_valid = 1'b1;
            if (!rxd)
            begin
                state_next.rx_frame_err = 1'b1;
            end
        end
        if (!flow_sw)
        begin
            state_next.paused = 1'b0;
        end

        // ============================================================
        // transmitter [R5] [R1] [R2] [R3]
        may_start = flow_sw ? !state_reg.paused : !cts_n; // [R11] [R4]
        case (state_reg.tx_state)
            TX_IDLE:
            begin
                state_next.txd = 1'b1;
                if (state_reg.tx_pending && may_start)
                begin
                    state_next.tx_shift = state_reg.tx_hold;
                    state_next.tx_pending = 1'b0;
                    state_next.tx_state = TX_START;
                    state_next.tx_cnt = '0;
                    state_next.txd = 1'b0;
                end
            end
            TX_START, TX_DATA:
            begin
                state_next.tx_cnt = state_reg.tx_cnt + 1'b1;
                if (state_reg.tx_cnt == BIT_LAST)
                begin
                    state_next.tx_cnt = '0;
                    if (state_reg.tx_state == TX_START)
                    begin
                        state_next.tx_state = TX_DATA;
                        state_next.tx_bit = '0;
                        state_next.txd = state_reg.tx_shift[0];
                    end
                    else if (state_reg.tx_bit == LAST_BIT)
                    begin
                        state_next.tx_state = TX_STOP;
                        state_next.txd = 1'b1;
                    end
                    else
                    begin
                        state_next.tx_bit = state_reg.tx_bit + 1'b1;
                        state_next.tx_shift = {1'b0, state_reg.tx_shift[7:1]};
                        state_next.txd = state_reg.tx_shift[1];
                    end
                end
            end
            TX_STOP:
            begin
                state_next.tx_cnt = state_reg.tx_cnt + 1'b1;
                if (state_reg.tx_cnt == BIT_LAST)
                begin
                    state_next.tx_state = TX_IDLE;
                end
            end
            default:
            begin
                state_next.tx_state = TX_IDLE;
            end
        endcase
        if (state_next.tx_pending == 1'b0 && WR_I && ADDR_I == spsl_pkg::REG_DATA
            && state_reg.tx_pending)
        begin
            state_next.tx_pending = 1'b0;
        end

        // modem control outputs, active low on the line [R6] [R8] [R9]
        state_next.dtr_n = !state_next.ctrl[spsl_pkg::CTRL_DTR];
        state_next.rts_n = !state_next.ctrl[spsl_pkg::CTRL_RTS];
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_reg <= '0;
            state_reg.ctrl <= spsl_pkg::CTRL_RESET;
            state_reg.tx_state <= TX_IDLE;
            state_reg.rx_state <= RX_IDLE;
            state_reg.txd <= 1'b1;
            state_reg.rts_n <= 1'b0;
            state_reg.dtr_n <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign RDATA_O = state_reg.rdata;
    assign TXD_O = state_reg.txd;
    assign RTS_N_O = state_reg.rts_n;
    assign DTR_N_O = state_reg.dtr_n;
endmodule

// file: dv/spsl_checker.sv
// assertion checker for the service port serial link
`timescale 1ns/1ps
module spsl_checker (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // register port
    input wire logic [1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    // serial pins
    input wire logic CTS_N_I,
    input wire logic TXD_O,
    input wire logic RTS_N_O,
    input wire logic DTR_N_O
);
    localparam int BIT = spsl_pkg::BIT_CYCLES;
    localparam int FRAME = 10 * BIT;
    int cnt;
    logic [2:0] ctrl_q;
    logic sw_mode;
    assign sw_mode = ctrl_q[spsl_pkg::CTRL_FLOW_SW];
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    // =====================================
    // frame position, 0 while the line idles
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            cnt <= 0;
            ctrl_q <= spsl_pkg::CTRL_RESET;
        end
        else
        begin
            if (cnt == 0)
                cnt <= TXD_O ? 0 : 1;
            else
                cnt <= (cnt == FRAME) ? 0 : cnt + 1;
            if (WR_I && ADDR_I == spsl_pkg::REG_CTRL)
                ctrl_q <= WDATA_I[2:0];
        end
    end
    chk_start_low: assert property (cnt != 0 && cnt < BIT |-> !TXD_O)
        else $error("start bit not held low");
    chk_bit_hold: assert property (cnt != 0 && cnt % BIT != 0 |-> $stable(TXD_O))
        else $error("serial bit changed inside its time");
    chk_stop_high: assert property (cnt >= 9 * BIT |-> TXD_O)
        else $error("stop bit or gap not high");
    // two high pin samples in a row would have forced the filtered level high
    chk_cts_start: assert property (cnt == 0 && !TXD_O && !sw_mode |->
        !($past(CTS_N_I, 4) && $past(CTS_N_I, 5)))
        else $error("character started with clear to send off");
    chk_cts_hold: assert property ((CTS_N_I && !sw_mode) [*8] |-> cnt != 0 || TXD_O)
        else $error("start while clear to send held off");
    chk_line_ctrl: assert property (ctrl_q == $past(ctrl_q, 2) |->
        RTS_N_O == !ctrl_q[spsl_pkg::CTRL_RTS] && DTR_N_O == !ctrl_q[spsl_pkg::CTRL_DTR])
        else $error("modem outputs do not follow control");
    chk_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data outside its cycle");
    chk_busy_flag: assert property ($past(RD_I) && $past(ADDR_I) == spsl_pkg::REG_STATUS
        && $past(cnt) > 1 && $past(cnt) < FRAME |-> RDATA_O[spsl_pkg::ST_TX_BUSY])
        else $error("busy clear while sending");
    cover property (cnt == FRAME);
    cover property (WR_I && ADDR_I == spsl_pkg::REG_CTRL);
    cover property (RD_I && ADDR_I == spsl_pkg::REG_STATUS);
endmodule
bind spsl_top spsl_checker chk_u (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CTS_N_I(CTS_N_I),
    .TXD_O(TXD_O), .RTS_N_O(RTS_N_O), .DTR_N_O(DTR_N_O));

// file: dv/spsl_term.sv
// operator terminal model at the far end of the null modem cable
`timescale 1ns/1ps
module spsl_term (
    // clock
    input wire logic clock_i,
    // crossed pairs
    input wire logic txd_i,
    input wire logic rts_n_i,
    output logic rxd_o,
    output logic cts_n_o,
    output logic dsr_n_o
);
    localparam int BIT = spsl_pkg::BIT_CYCLES;
    initial
    begin
        rxd_o = 1'b1;
        cts_n_o = 1'b1;
        dsr_n_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // =====================================
    // frames: lsb first, no parity, one stop bit
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        // hardware flow: hold off until the device asks
        while (rts_n_i !== 1'b0) tick(1);
        for (int i = 0; i < 10; i++)
        begin
            rxd_o <= f[i];
            tick(BIT);
        end
    endtask
    task automatic get_byte(output logic [7:0] b, output logic stop);
        @(negedge txd_i);
        tick(BIT / 2);
        for (int i = 0; i < 8; i++)
        begin
            tick(BIT);
            b[i] = txd_i;
        end
        tick(BIT);
        stop = txd_i;
    endtask
endmodule

// file: dv/tb_spsl_top.sv
// self-checking bench for the service port serial link
`timescale 1ns/1ps
module tb_spsl_top;
    logic clock, rst_n, wr, rd, dcd_n, ri_n, txd, rts_n, dtr_n, rxd, cts_n, dsr_n, stop;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, got;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    initial clock = 1'b0;
    always #5 clock = ~clock;
    spsl_top dut_u (.CLOCK_I(clock), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RXD_I(rxd), .CTS_N_I(cts_n),
        .DSR_N_I(dsr_n), .DCD_N_I(dcd_n), .RI_N_I(ri_n), .TXD_O(txd), .RTS_N_O(rts_n),
        .DTR_N_O(dtr_n));
    spsl_term term_u (.clock_i(clock), .txd_i(txd), .rts_n_i(rts_n), .rxd_o(rxd),
        .cts_n_o(cts_n), .dsr_n_o(dsr_n));
    // =====================================
    // access tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        // one idle edge, so a following write never reassigns the strobe at once
        @(posedge clock);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] want);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        check(rdata, want);
        @(posedge clock);
    endtask
    task automatic report_and_stop();
        $display("checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // two frame times plus setup fit inside this ceiling
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 110000)
        begin
            n_errors++;
            report_and_stop();
        end
    end
    // =====================================
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        dcd_n = 1'b1;
        ri_n = 1'b1;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        rd_chk(spsl_pkg::REG_CTRL, 8'h06);
        rd_chk(spsl_pkg::REG_STATUS, 8'h40);
        check({6'h00, rts_n, dtr_n}, 8'h00);
        reg_write(spsl_pkg::REG_CTRL, 8'h00);
        repeat (4) @(posedge clock);
        check({6'h00, rts_n, dtr_n}, 8'h03);
        reg_write(spsl_pkg::REG_CTRL, 8'h06);
        rd_chk(2'h3, 8'h00);
        // clear to send held off: the character waits
        reg_write(spsl_pkg::REG_DATA, 8'hA5);
        repeat (200) @(posedge clock);
        check({7'h00, txd}, 8'h01);
        rd_chk(spsl_pkg::REG_STATUS, 8'h41);
        term_u.cts_n_o <= 1'b0;
        dcd_n <= 1'b0;
        ri_n <= 1'b0;
        fork
            term_u.get_byte(got, stop);
            term_u.send_byte(8'h3C);
        join
        check(got, 8'hA5);
        check({7'h00, stop}, 8'h01);
        repeat (40) @(posedge clock);
        rd_chk(spsl_pkg::REG_STATUS, 8'h62);
        rd_chk(spsl_pkg::REG_DATA, 8'h3C);
        rd_chk(spsl_pkg::REG_STATUS, 8'h60);
        // in-band flow: clear to send no longer gates a start, Xoff holds the next one
        term_u.cts_n_o <= 1'b1;
        fork
            term_u.send_byte(spsl_pkg::XOFF_CHAR);
            begin
                reg_write(spsl_pkg::REG_CTRL, 8'h07);
                reg_write(spsl_pkg::REG_DATA, 8'h5A);
                repeat (20) @(posedge clock);
                check({7'h00, txd}, 8'h00);
                rd_chk(spsl_pkg::REG_STATUS, 8'h41);
            end
        join
        // flow character is consumed, not stored, and the pending byte waits
        reg_write(spsl_pkg::REG_DATA, 8'h77);
        repeat (100) @(posedge clock);
        check({7'h00, txd}, 8'h01);
        rd_chk(spsl_pkg::REG_STATUS, 8'h51);
        report_and_stop();
    end
endmodule
